// ---- hw/csr_pkg.sv ----
/*
  Constants, register map and carriers for the core special register block.
  Assumes an APB master on a single 250 MHz clock with active-low asynchronous reset.
*/
//
// Function
// - The program counter loads zero at reset so the first fetch is from address zero.
// - Multiply takes both operands as 8-bit unsigned, product low byte to the main operand, high byte to the second.
// - Divide leaves the quotient in the main operand register and the remainder in the second operand register.
// - The stack pointer resets to 07h and is incremented before each push so the first byte lands at 08h.
// - RAM addresses 08h to 1Fh hold working banks 1 to 3, overlapping the default stack region.
// - The carry flag, bit 7, reports carry out of or borrow into the top bit of add and subtract.
// - The half carry flag, bit 6, reports carry out of or borrow into bit 3.
// - Status bits 4 and 3 select which 8-byte bank R0 to R7 map onto.
// - The parity flag, bit 0, always equals the odd parity of the main operand register.
// - The 16-bit data pointer is built from a low byte at 82h and a high byte at 83h.
package csr_pkg;
  // ==========================================================================
  // Register map, as word indexes: the byte address on the bus is four times the index.
  localparam logic [7:0] CSR_OFF_SP = 8'h81;
  localparam logic [7:0] CSR_OFF_DPL = 8'h82;
  localparam logic [7:0] CSR_OFF_DPH = 8'h83;
  localparam logic [7:0] CSR_OFF_PSW = 8'hd0;
  localparam logic [7:0] CSR_OFF_ACC = 8'he0;
  localparam logic [7:0] CSR_OFF_B = 8'hf0;
  localparam logic [7:0] CSR_OFF_PCL = 8'h10;
  localparam logic [7:0] CSR_OFF_PCH = 8'h14;
  localparam logic [7:0] CSR_OFF_OP = 8'h18;
  localparam logic [7:0] CSR_OFF_BANK = 8'h1c;
  // ==========================================================================
  // Reset values
  localparam logic [7:0] CSR_RST_SP = 8'h07;
  localparam logic [7:0] CSR_RST_BYTE = 8'h00;
  localparam logic [15:0] CSR_RST_PC = 16'h0000;
  // ==========================================================================
  // Status word fields
  localparam int CSR_BIT_CY = 7;
  localparam int CSR_BIT_AC = 6;
  localparam int CSR_BIT_F0 = 5;
  localparam int CSR_BIT_RS1 = 4;
  localparam int CSR_BIT_RS0 = 3;
  localparam int CSR_BIT_OV = 2;
  localparam int CSR_BIT_F1 = 1;
  localparam int CSR_BIT_P = 0;
  localparam logic [7:0] CSR_PSW_WMASK = 8'hfe;
  // ==========================================================================
  // Operation codes written to the operation register
  typedef enum logic [7:0] {
    CSR_OP_NONE = 8'h00,
    CSR_OP_ADD = 8'h01,
    CSR_OP_ADDC = 8'h02,
    CSR_OP_SUBB = 8'h03,
    CSR_OP_MUL = 8'h04,
    CSR_OP_DIV = 8'h05,
    CSR_OP_PUSH = 8'h06,
    CSR_OP_POP = 8'h07,
    CSR_OP_INCDP = 8'h08
  } csr_op_t;
  typedef struct packed {
    logic [7:0] quot;
    logic [7:0] rem;
    logic by_zero;
  } csr_div_t;
endpackage

// ---- hw/csr_divider.sv ----
/*
  Combinational 8-bit unsigned restoring divider.
  Flags division by zero itself in by_zero; quotient and remainder are then all ones and the dividend.
*/
module csr_divider (
  input wire logic [7:0] dividend,
  input wire logic [7:0] divisor,
  output csr_pkg::csr_div_t result
);
  logic [8:0] part [0:8];
  logic [7:0] q;
  // ==========================================================================
  // Long division, one bit per stage
  assign part[0] = 9'h000;
  for (genvar i = 0; i < 8; i++) begin : g_stage
    logic [8:0] trial;
    assign trial = {part[i][7:0], dividend[7 - i]};
    assign q[7 - i] = (trial >= {1'b0, divisor});
    assign part[i + 1] = q[7 - i] ? (trial - {1'b0, divisor}) : trial;
  end
  assign result.quot = q;
  assign result.rem = part[8][7:0];
  assign result.by_zero = (divisor == 8'h00);
endmodule

// ---- hw/csr_core_regs.sv ----
/*
  Core special registers behind an APB slave, with a small arithmetic engine that
  updates the operand registers and status flags as the instruction datapath would.
  Assumes an APB master on pclk; every access completes with no wait state.
*/
// Chosen here: the APB interface to the registers.
module csr_core_regs (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [15:0] program_counter,
  output logic [15:0] data_pointer_16,
  output logic [7:0] bank_base
);
  logic [7:0] stack_top_pointer, next_stack_top_pointer;
  logic [7:0] data_pointer_low, next_data_pointer_low;
  logic [7:0] data_pointer_high, next_data_pointer_high;
  logic [7:0] psw_q, next_psw_q;
  logic [7:0] main_operand_reg, next_main_operand_reg;
  logic [7:0] second_operand_reg, next_second_operand_reg;
  logic [15:0] next_program_counter;
  logic [31:0] next_prdata;
  logic [7:0] program_status_word;
  logic wr_en, rd_en, hit, wr_lane0;
  logic [7:0] wbyte;
  logic [8:0] sum9;
  logic [4:0] half5;
  logic [7:0] sum_signed_a, sum_signed_b;
  logic [15:0] product;
  logic cin;
  csr_pkg::csr_div_t div_res;
  csr_pkg::csr_op_t op;

  // ==========================================================================
  // APB decode
  logic [7:0] idx;
  logic aligned;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;
  assign wr_lane0 = pstrb[0];
  assign wbyte = pwdata[7:0];
  assign pready = 1'b1;
  assign op = csr_pkg::csr_op_t'(wbyte);
  // Each register owns one aligned word, so the index sits in address bits 9:2.
  assign idx = paddr[9:2];
  assign aligned = paddr[11:10] == 2'b00 && paddr[1:0] == 2'b00;
  always_comb begin
    case (idx)
      csr_pkg::CSR_OFF_SP, csr_pkg::CSR_OFF_DPL, csr_pkg::CSR_OFF_DPH, csr_pkg::CSR_OFF_PSW,
      csr_pkg::CSR_OFF_ACC, csr_pkg::CSR_OFF_B, csr_pkg::CSR_OFF_PCL, csr_pkg::CSR_OFF_PCH,
      csr_pkg::CSR_OFF_OP, csr_pkg::CSR_OFF_BANK: hit = aligned;
      default: hit = 1'b0;
    endcase
  end
  assign pslverr = psel && penable && !hit;

  // ==========================================================================
  // Flag helpers
  // Parity is derived, never stored, so it can never disagree with the operand.
  assign program_status_word = {psw_q[7:1], ^main_operand_reg};
  assign cin = (op == csr_pkg::CSR_OP_ADDC || op == csr_pkg::CSR_OP_SUBB) ? psw_q[csr_pkg::CSR_BIT_CY] : 1'b0;
  assign sum_signed_a = main_operand_reg;
  assign sum_signed_b = (op == csr_pkg::CSR_OP_SUBB) ? ~second_operand_reg : second_operand_reg;
  always_comb begin
    if (op == csr_pkg::CSR_OP_SUBB) begin
      sum9 = {1'b0, main_operand_reg} - {1'b0, second_operand_reg} - {8'h00, cin};
      half5 = {1'b0, main_operand_reg[3:0]} - {1'b0, second_operand_reg[3:0]} - {4'h0, cin};
    end else begin
      sum9 = {1'b0, main_operand_reg} + {1'b0, second_operand_reg} + {8'h00, cin};
      half5 = {1'b0, main_operand_reg[3:0]} + {1'b0, second_operand_reg[3:0]} + {4'h0, cin};
    end
  end
  assign product = main_operand_reg * second_operand_reg;
  csr_divider u_div (
    .dividend(main_operand_reg),
    .divisor(second_operand_reg),
    .result(div_res)
  );

  // ==========================================================================
  // Register next state
  always_comb begin
    next_stack_top_pointer = stack_top_pointer;
    next_data_pointer_low = data_pointer_low;
    next_data_pointer_high = data_pointer_high;
    next_psw_q = psw_q;
    next_main_operand_reg = main_operand_reg;
    next_second_operand_reg = second_operand_reg;
    next_program_counter = program_counter;
    if (wr_en && wr_lane0 && aligned) begin
      case (idx)
        csr_pkg::CSR_OFF_SP: next_stack_top_pointer = wbyte;
        csr_pkg::CSR_OFF_PSW: next_psw_q = wbyte & csr_pkg::CSR_PSW_WMASK;
        csr_pkg::CSR_OFF_ACC: next_main_operand_reg = wbyte;
        csr_pkg::CSR_OFF_B: next_second_operand_reg = wbyte;
        csr_pkg::CSR_OFF_PCL: next_program_counter = {program_counter[15:8], wbyte};
        csr_pkg::CSR_OFF_PCH: next_program_counter = {wbyte, program_counter[7:0]};
        csr_pkg::CSR_OFF_OP: begin
          case (op)
            csr_pkg::CSR_OP_ADD, csr_pkg::CSR_OP_ADDC, csr_pkg::CSR_OP_SUBB: begin
              next_main_operand_reg = sum9[7:0];
              next_psw_q[csr_pkg::CSR_BIT_CY] = sum9[8];
              next_psw_q[csr_pkg::CSR_BIT_AC] = half5[4];
              next_psw_q[csr_pkg::CSR_BIT_OV] = (sum_signed_a[7] == sum_signed_b[7]) &&
                (sum9[7] != sum_signed_a[7]);
            end
            csr_pkg::CSR_OP_MUL: begin
              next_main_operand_reg = product[7:0];
              next_second_operand_reg = product[15:8];
              next_psw_q[csr_pkg::CSR_BIT_CY] = 1'b0;
              next_psw_q[csr_pkg::CSR_BIT_OV] = (product[15:8] != 8'h00);
            end
            csr_pkg::CSR_OP_DIV: begin
              next_psw_q[csr_pkg::CSR_BIT_CY] = 1'b0;
              next_psw_q[csr_pkg::CSR_BIT_OV] = div_res.by_zero;
              if (!div_res.by_zero) begin
                next_main_operand_reg = div_res.quot;
                next_second_operand_reg = div_res.rem;
              end
            end
            // Pre-increment keeps the pointer on the last byte written.
            csr_pkg::CSR_OP_PUSH: next_stack_top_pointer = stack_top_pointer + 8'h01;
            csr_pkg::CSR_OP_POP: next_stack_top_pointer = stack_top_pointer - 8'h01;
            csr_pkg::CSR_OP_INCDP: {next_data_pointer_high, next_data_pointer_low} = data_pointer_16 + 16'h0001;
            csr_pkg::CSR_OP_NONE: next_program_counter = program_counter;
            default: next_program_counter = program_counter;
          endcase
        end
        default: begin
          if (idx == csr_pkg::CSR_OFF_DPL) next_data_pointer_low = wbyte;
          if (idx == csr_pkg::CSR_OFF_DPH) next_data_pointer_high = wbyte;
        end
      endcase
    end
  end

  always_comb begin
    next_prdata = prdata;
    if (rd_en) begin
      case ({aligned, idx})
        {1'b1, csr_pkg::CSR_OFF_SP}: next_prdata = {24'h000000, stack_top_pointer};
        {1'b1, csr_pkg::CSR_OFF_DPL}: next_prdata = {24'h000000, data_pointer_low};
        {1'b1, csr_pkg::CSR_OFF_DPH}: next_prdata = {24'h000000, data_pointer_high};
        {1'b1, csr_pkg::CSR_OFF_PSW}: next_prdata = {24'h000000, program_status_word};
        {1'b1, csr_pkg::CSR_OFF_ACC}: next_prdata = {24'h000000, main_operand_reg};
        {1'b1, csr_pkg::CSR_OFF_B}: next_prdata = {24'h000000, second_operand_reg};
        {1'b1, csr_pkg::CSR_OFF_PCL}: next_prdata = {24'h000000, program_counter[7:0]};
        {1'b1, csr_pkg::CSR_OFF_PCH}: next_prdata = {24'h000000, program_counter[15:8]};
        {1'b1, csr_pkg::CSR_OFF_BANK}: next_prdata = {24'h000000, bank_base};
        default: next_prdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stack_top_pointer <= csr_pkg::CSR_RST_SP;
      data_pointer_low <= csr_pkg::CSR_RST_BYTE;
      data_pointer_high <= csr_pkg::CSR_RST_BYTE;
      psw_q <= csr_pkg::CSR_RST_BYTE;
      main_operand_reg <= csr_pkg::CSR_RST_BYTE;
      second_operand_reg <= csr_pkg::CSR_RST_BYTE;
      program_counter <= csr_pkg::CSR_RST_PC;
      prdata <= 32'h00000000;
    end else begin
      stack_top_pointer <= next_stack_top_pointer;
      data_pointer_low <= next_data_pointer_low;
      data_pointer_high <= next_data_pointer_high;
      psw_q <= next_psw_q;
      main_operand_reg <= next_main_operand_reg;
      second_operand_reg <= next_second_operand_reg;
      program_counter <= next_program_counter;
      prdata <= next_prdata;
    end
  end

  // ==========================================================================
  // Derived outputs
  assign data_pointer_16 = {data_pointer_high, data_pointer_low};
  // Banks 1 to 3 sit at 08h..1Fh, the same bytes the default stack grows into.
  assign bank_base = {3'b000, psw_q[csr_pkg::CSR_BIT_RS1], psw_q[csr_pkg::CSR_BIT_RS0], 3'b000};

  // ==========================================================================
  // Checks
  logic op_wr;
  assign op_wr = wr_en && pstrb[0] && paddr == {2'b00, csr_pkg::CSR_OFF_OP, 2'b00};
  AST_PC_RESET: assert property (@(posedge pclk) $rose(presetn) |-> program_counter == 16'h0000)
    else $error("program counter not zero after reset");
  AST_MUL: assert property (@(posedge pclk) disable iff (!presetn)
    op_wr && op == csr_pkg::CSR_OP_MUL |=> {second_operand_reg, main_operand_reg} ==
    $past(main_operand_reg) * $past(second_operand_reg))
    else $error("multiply result wrong");
  AST_DIV: assert property (@(posedge pclk) disable iff (!presetn)
    op_wr && op == csr_pkg::CSR_OP_DIV && second_operand_reg != 8'h00 |=>
    main_operand_reg * $past(second_operand_reg) + second_operand_reg == 16'($past(main_operand_reg)))
    else $error("divide result wrong");
  AST_PUSH: assert property (@(posedge pclk) disable iff (!presetn)
    op_wr && op == csr_pkg::CSR_OP_PUSH |=> stack_top_pointer == $past(stack_top_pointer) + 8'h01)
    else $error("push did not pre-increment");
  AST_BANK: assert property (@(posedge pclk) disable iff (!presetn)
    bank_base == {3'b000, program_status_word[4:3], 3'b000} && bank_base <= 8'h18)
    else $error("bank base mismatch");
  AST_PARITY: assert property (@(posedge pclk) disable iff (!presetn)
    program_status_word[0] == ^main_operand_reg)
    else $error("parity flag wrong");
  AST_CARRY: assert property (@(posedge pclk) disable iff (!presetn)
    op_wr && op == csr_pkg::CSR_OP_ADD |=>
    psw_q[7] == (9'($past(main_operand_reg)) + 9'($past(second_operand_reg)) > 9'h0ff))
    else $error("carry flag wrong");
  AST_HALF: assert property (@(posedge pclk) disable iff (!presetn)
    op_wr && op == csr_pkg::CSR_OP_ADD |=>
    psw_q[6] == (5'($past(main_operand_reg[3:0])) + 5'($past(second_operand_reg[3:0])) > 5'h0f))
    else $error("half carry flag wrong");
  AST_DIVZ: assert property (@(posedge pclk) disable iff (!presetn)
    op_wr && op == csr_pkg::CSR_OP_DIV && second_operand_reg == 8'h00 |=> psw_q[2] && $stable(main_operand_reg))
    else $error("divide by zero not flagged");
  AST_DATA_POINTER_16: assert property (@(posedge pclk) disable iff (!presetn)
    op_wr && op == csr_pkg::CSR_OP_INCDP |=> data_pointer_16 == $past(data_pointer_16) + 16'h0001)
    else $error("data pointer increment wrong");
  AST_PSW_WR: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && pstrb[0] && paddr == {2'b00, csr_pkg::CSR_OFF_PSW, 2'b00} |=> psw_q[7:1] == $past(pwdata[7:1]))
    else $error("status word write lost");
endmodule

// ---- dv/tb_top.sv ----
/*
  Self-checking bench for the core special register block, with a reference model in plain vectors.
  Assumes the APB slave answers with no wait states and that arithmetic works on main and second operand.
*/
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin fail_count++; \
  $display("BAD %s expected %h seen %h", nm, e, g); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // Clock, reset and stimulus signals
  logic pclk;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [3:0] pstrb = 4'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [15:0] program_counter;
  logic [15:0] data_pointer_16;
  logic [7:0] bank_base;
  int fail_count = 0;
  int n_tests = 0;
  int cyc = 0;
  logic [31:0] rd;
  logic err;
  logic [7:0] acc, bb, p, opc;
  logic [8:0] s;
  logic [4:0] h;
  logic [15:0] pr;
  logic cy, ac, ov;
  csr_pkg::csr_op_t ops [5] = '{csr_pkg::CSR_OP_ADD, csr_pkg::CSR_OP_ADDC, csr_pkg::CSR_OP_SUBB,
                                csr_pkg::CSR_OP_MUL, csr_pkg::CSR_OP_DIV};
  csr_core_regs csr_core_regs_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .program_counter(program_counter), .data_pointer_16(data_pointer_16),
    .bank_base(bank_base));
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  // ==========================================================================
  // Bus tasks
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] st);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= st;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, {2'b00, a, 2'b00}, {24'h000000, d}, 4'hf);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e, input string nm);
    apb(1'b0, {2'b00, a, 2'b00}, 32'h00000000, 4'h0);
    `CHK(nm, {24'h000000, e}, rd)
  endtask
  task automatic summarize();
    $display("Checks %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // A hung handshake would otherwise stall the run forever.
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      summarize();
    end
  end
  // ==========================================================================
  // Main sequence
  initial begin
    void'($urandom(77031));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    `CHK("pc", 16'h0000, program_counter)
    rd_chk(csr_pkg::CSR_OFF_SP, 8'h07, "sp");
    rd_chk(csr_pkg::CSR_OFF_PSW, 8'h00, "psw");
    rd_chk(csr_pkg::CSR_OFF_ACC, 8'h00, "acc");
    rd_chk(csr_pkg::CSR_OFF_B, 8'h00, "b");
    wr(csr_pkg::CSR_OFF_OP, csr_pkg::CSR_OP_PUSH);
    rd_chk(csr_pkg::CSR_OFF_SP, 8'h08, "sp push");
    wr(csr_pkg::CSR_OFF_OP, csr_pkg::CSR_OP_POP);
    rd_chk(csr_pkg::CSR_OFF_SP, 8'h07, "sp pop");
    for (int r = 0; r < 4; r++) begin
      wr(csr_pkg::CSR_OFF_PSW, {3'b101, 2'(r), 3'b010});
      @(negedge pclk);
      `CHK("bank", {3'b000, 2'(r), 3'b000}, bank_base)
      rd_chk(csr_pkg::CSR_OFF_PSW, {3'b101, 2'(r), 3'b010}, "psw rw");
    end
    wr(csr_pkg::CSR_OFF_DPL, 8'hff);
    wr(csr_pkg::CSR_OFF_DPH, 8'h12);
    wr(csr_pkg::CSR_OFF_OP, csr_pkg::CSR_OP_INCDP);
    @(negedge pclk);
    `CHK("data_pointer_16", 16'h1300, data_pointer_16)
    rd_chk(csr_pkg::CSR_OFF_DPL, 8'h00, "dpl");
    rd_chk(csr_pkg::CSR_OFF_DPH, 8'h13, "dph");
    for (int i = 0; i < 60; i++) begin
      acc = 8'($urandom);
      bb = (i % 8 == 0) ? 8'h00 : 8'($urandom);
      p = 8'($urandom);
      opc = ops[$urandom % 5];
      wr(csr_pkg::CSR_OFF_ACC, acc);
      wr(csr_pkg::CSR_OFF_B, bb);
      wr(csr_pkg::CSR_OFF_PSW, p);
      cy = p[7];
      ac = p[6];
      ov = p[2];
      if (opc == csr_pkg::CSR_OP_ADD || opc == csr_pkg::CSR_OP_ADDC) begin
        if (opc == csr_pkg::CSR_OP_ADD) cy = 1'b0;
        s = acc + bb + cy;
        h = acc[3:0] + bb[3:0] + cy;
        ov = (acc[7] == bb[7]) && (s[7] != acc[7]);
        acc = s[7:0];
        cy = s[8];
        ac = h[4];
      end else if (opc == csr_pkg::CSR_OP_SUBB) begin
        s = {1'b0, acc} - {1'b0, bb} - cy;
        h = {1'b0, acc[3:0]} - {1'b0, bb[3:0]} - cy;
        ov = (acc[7] != bb[7]) && (s[7] != acc[7]);
        acc = s[7:0];
        cy = s[8];
        ac = h[4];
      end else if (opc == csr_pkg::CSR_OP_MUL) begin
        pr = acc * bb;
        acc = pr[7:0];
        bb = pr[15:8];
        cy = 1'b0;
        ov = pr > 16'h00ff;
      end else begin
        cy = 1'b0;
        ov = bb == 8'h00;
        if (!ov) begin
          pr = {acc / bb, acc % bb};
          acc = pr[15:8];
          bb = pr[7:0];
        end
      end
      wr(csr_pkg::CSR_OFF_OP, opc);
      rd_chk(csr_pkg::CSR_OFF_ACC, acc, "acc result");
      rd_chk(csr_pkg::CSR_OFF_B, bb, "b result");
      rd_chk(csr_pkg::CSR_OFF_PSW, {cy, ac, p[5:3], ov, p[1], ^acc}, "psw flags");
    end
    // Refused accesses must leave the model state untouched.
    apb(1'b1, 12'h300, 32'h000000ff, 4'hf);
    `CHK("slverr wr", 1'b1, err)
    apb(1'b0, 12'h300, 32'h00000000, 4'h0);
    `CHK("slverr rd", 1'b1, err)
    `CHK("unmapped rd", 32'h00000000, rd)
    apb(1'b1, {2'b00, csr_pkg::CSR_OFF_ACC, 2'b00}, {24'h000000, ~acc}, 4'h0);
    rd_chk(csr_pkg::CSR_OFF_ACC, acc, "strobe off");
    wr(csr_pkg::CSR_OFF_PCL, 8'h34);
    wr(csr_pkg::CSR_OFF_PCH, 8'h12);
    wr(csr_pkg::CSR_OFF_OP, csr_pkg::CSR_OP_PUSH);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    `CHK("pc rst", 16'h0000, program_counter)
    rd_chk(csr_pkg::CSR_OFF_SP, 8'h07, "sp rst");
    rd_chk(csr_pkg::CSR_OFF_PSW, 8'h00, "psw rst");
    summarize();
  end
endmodule
